// *** inc/mcmc_defs.svh ***
`ifndef MCMC_DEFS_SVH
`define MCMC_DEFS_SVH

// ****************************************
// Channel function select register
// ****************************************
`define MCMC_CHMODE_RST     8'h00
`define MCMC_BIT_AUX_A      0
`define MCMC_BIT_AUX_B      1
`define MCMC_BIT_DIODE_B    2
`define MCMC_BIT_VCC_5V     3
`define MCMC_BIT_EXT_IRQ_0_EN    4
`define MCMC_BIT_EXT_IRQ_2_EN    6
`define MCMC_BIT_VID_IRQ    7

// ****************************************
// Converter codes and timing
// ****************************************
`define MCMC_NOMINAL_CODE   8'hC0
`define MCMC_FULL_CODE      8'hFF
`define MCMC_TEMP_AVG_N     16
`define MCMC_TEMP_AVG_LAST  4'hF
`define MCMC_CLK_PERIOD_NS  5
`define MCMC_CONV_PERIOD_US 748
`define MCMC_TEMP_MEAS_US   9600
`define MCMC_NS_PER_US      1000

`endif

// *** inc/mcmc_pkg.sv ***
package mcmc_pkg;

  // ****************************************
  // Measurement channels
  // ****************************************
  typedef enum logic [3:0] {
    MCMC_CH_12V     = 4'h0,
    MCMC_CH_5V      = 4'h1,
    MCMC_CH_VCC     = 4'h2,
    MCMC_CH_CORE_A  = 4'h3,
    MCMC_CH_DIODE_A = 4'h4,
    MCMC_CH_AUX_A   = 4'h5,
    MCMC_CH_AUX_B   = 4'h6,
    MCMC_CH_2V5     = 4'h7,
    MCMC_CH_CORE_B  = 4'h8,
    MCMC_CH_DIODE_B = 4'h9
  } mcmc_chan_t;

  localparam logic [3:0] MCMC_CH_COUNT = 4'hA;

  typedef enum logic [1:0] {
    MCMC_ST_WAIT = 2'b00,
    MCMC_ST_CONV = 2'b01
  } mcmc_state_t;

  // ****************************************
  // Decoded pin functions
  // ****************************************
  typedef struct packed {
    logic       aux_a_sel;
    logic       aux_b_sel;
    logic       diode_b_sel;
    logic       vcc_5v;
    logic       vid_irq_mode;
    logic [4:0] irq_en;
  } mcmc_cfg_t;

  typedef struct packed {
    logic       valid;
    mcmc_chan_t chan;
    logic [7:0] data;
  } mcmc_result_t;

endpackage : mcmc_pkg

// *** rtl/mcmc_ctrl.sv ***
`timescale 1ns/1ps
`include "mcmc_defs.svh"
// Contract
// RULE_01 - Mode bit 0/1 pick tach (0) or aux analog (1) for shared pins a/b.
// RULE_02 - Mode bit 2 picks 2.5 V plus core b (0) or remote diode b (1).
// RULE_03 - Mode bit 3 sets internal supply range: 3.3 V when 0, 5 V when 1.
// RULE_04 - Mode bit 7 turns all five voltage-ID pins into interrupt inputs.
// RULE_05 - In interrupt mode, mode bits 4..6 enable interrupts on ID pins 0..2.
// RULE_06 - Interrupt enables for ID pins 3 and 4 come from second config bits 6,7.
// RULE_07 - Dedicated diode a, 12 V, 5 V and core a channels never change.
// RULE_08 - Mode register resets to zero.
// RULE_09 - One shared successive-approximation converter, unsigned 8-bit result.
// RULE_10 - Supply inputs scaled so nominal voltage reads three-quarter scale.
// RULE_11 - Code is zero below first step, saturates at 255 above range.
// RULE_12 - One voltage conversion every 748 us while running.
// RULE_13 - Diode results average sixteen conversions, 9.6 ms per measurement.
// RULE_14 - Diode results are signed 8-bit two's-complement degrees Celsius.
// RULE_15 - Sequencer round-robins enabled channels, skipping fan and interrupt pins.

module mcmc_ctrl #(
  parameter int CONV_CYCLES = (`MCMC_CONV_PERIOD_US * `MCMC_NS_PER_US) / `MCMC_CLK_PERIOD_NS,
  parameter int TEMP_CYCLES = (`MCMC_TEMP_MEAS_US * `MCMC_NS_PER_US)
                              / (`MCMC_CLK_PERIOD_NS * `MCMC_TEMP_AVG_N)
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Register port
  input  wire logic                  i_reg_wr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic [1:0]            i_cfg2_irq_en,
  // Pin functions
  output mcmc_pkg::mcmc_cfg_t        o_cfg,
  // Converter
  input  wire logic                  i_run,
  output logic                       o_adc_start,
  output mcmc_pkg::mcmc_chan_t       o_mux_sel,
  input  wire logic                  i_adc_done,
  input  wire logic [8:0]            i_adc_raw,
  // Results
  output mcmc_pkg::mcmc_result_t     o_result
);

  localparam logic [17:0] CONV_LAST = 18'(CONV_CYCLES - 1);
  localparam logic [17:0] TEMP_LAST = 18'(TEMP_CYCLES - 1);
  localparam logic [17:0] CONV_GAP  = 18'(CONV_CYCLES);
  localparam logic [17:0] TEMP_GAP  = 18'(TEMP_CYCLES);

  // ****************************************
  // Channel decode helpers
  // ****************************************
  function automatic logic is_temp(input mcmc_pkg::mcmc_chan_t c);
    is_temp = (c == mcmc_pkg::MCMC_CH_DIODE_A) || (c == mcmc_pkg::MCMC_CH_DIODE_B);
  endfunction : is_temp

  function automatic logic chan_on(input mcmc_pkg::mcmc_chan_t c, input logic [7:0] m);
    case (c)
      mcmc_pkg::MCMC_CH_AUX_A:   chan_on = m[`MCMC_BIT_AUX_A];    // RULE_01
      mcmc_pkg::MCMC_CH_AUX_B:   chan_on = m[`MCMC_BIT_AUX_B];    // RULE_01
      mcmc_pkg::MCMC_CH_2V5:     chan_on = !m[`MCMC_BIT_DIODE_B]; // RULE_02
      mcmc_pkg::MCMC_CH_CORE_B:  chan_on = !m[`MCMC_BIT_DIODE_B]; // RULE_02
      mcmc_pkg::MCMC_CH_DIODE_B: chan_on = m[`MCMC_BIT_DIODE_B];  // RULE_02
      default:                   chan_on = 1'b1;                  // RULE_07
    endcase
  endfunction : chan_on

  function automatic mcmc_pkg::mcmc_chan_t chan_after(input mcmc_pkg::mcmc_chan_t c,
                                                      input logic [7:0] m);
    logic [4:0] idx;
    logic       found;
    chan_after = mcmc_pkg::MCMC_CH_DIODE_A;
    found      = 1'b0;
    for (int i = 1; i <= 10; i++)
    begin
      idx = 5'(c) + 5'(i);
      if (idx >= 5'(mcmc_pkg::MCMC_CH_COUNT))
      begin
        idx = idx - 5'(mcmc_pkg::MCMC_CH_COUNT);
      end
      if (!found && chan_on(mcmc_pkg::mcmc_chan_t'(idx[3:0]), m))
      begin
        chan_after = mcmc_pkg::mcmc_chan_t'(idx[3:0]);     // RULE_15
        found      = 1'b1;
      end
    end
  endfunction : chan_after

  // ****************************************
  // Mode register and pin decode
  // ****************************************
  logic [7:0]          mode;
  logic [7:0]          next_mode;
  mcmc_pkg::mcmc_cfg_t cfg;
  mcmc_pkg::mcmc_cfg_t next_cfg;

  always_comb
  begin
    next_mode = i_reg_wr ? i_reg_wdata : mode;
    next_cfg.aux_a_sel    = next_mode[`MCMC_BIT_AUX_A];                 // RULE_01
    next_cfg.aux_b_sel    = next_mode[`MCMC_BIT_AUX_B];                 // RULE_01
    next_cfg.diode_b_sel  = next_mode[`MCMC_BIT_DIODE_B];               // RULE_02
    next_cfg.vcc_5v       = next_mode[`MCMC_BIT_VCC_5V];                // RULE_03 RULE_10
    next_cfg.vid_irq_mode = next_mode[`MCMC_BIT_VID_IRQ];               // RULE_04
    next_cfg.irq_en[2:0]  = next_mode[`MCMC_BIT_EXT_IRQ_2_EN:`MCMC_BIT_EXT_IRQ_0_EN]
                            & {3{next_mode[`MCMC_BIT_VID_IRQ]}};        // RULE_05
    next_cfg.irq_en[4:3]  = i_cfg2_irq_en & {2{next_mode[`MCMC_BIT_VID_IRQ]}}; // RULE_06
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode <= `MCMC_CHMODE_RST;                                         // RULE_08
      cfg  <= '0;                                                       // RULE_08
    end
    else
    begin
      mode <= next_mode;
      cfg  <= next_cfg;
    end
  end

  assign o_reg_rdata = mode;
  assign o_cfg       = cfg;

  // ****************************************
  // Conversion sequencer
  // ****************************************
  mcmc_pkg::mcmc_state_t  state;
  mcmc_pkg::mcmc_state_t  next_state;
  mcmc_pkg::mcmc_chan_t   chan;
  mcmc_pkg::mcmc_chan_t   next_chan;
  mcmc_pkg::mcmc_result_t result;
  mcmc_pkg::mcmc_result_t next_result;
  logic [17:0]            timer;
  logic [17:0]            next_timer;
  logic [3:0]             avg_cnt;
  logic [3:0]             next_avg_cnt;
  logic signed [11:0]     acc;
  logic signed [11:0]     next_acc;
  logic                   start;
  logic                   next_start;

  always_comb
  begin
    logic signed [11:0] sum;
    sum          = acc + 12'(signed'(i_adc_raw[7:0]));                 // RULE_14
    next_state   = state;
    next_chan    = chan;
    next_avg_cnt = avg_cnt;
    next_acc     = acc;
    next_start   = 1'b0;
    next_result  = result;
    next_result.valid = 1'b0;
    next_timer   = i_run ? timer + 18'h0_0001 : 18'h0_0000;
    case (state)
      mcmc_pkg::MCMC_ST_WAIT:
      begin
        if (i_run && (timer >= (is_temp(chan) ? TEMP_LAST : CONV_LAST))) // RULE_12 RULE_13
        begin
          next_timer = 18'h0_0000;
          next_start = 1'b1;
          next_state = mcmc_pkg::MCMC_ST_CONV;
        end
      end
      mcmc_pkg::MCMC_ST_CONV:
      begin
        if (i_adc_done)
        begin
          next_state = mcmc_pkg::MCMC_ST_WAIT;
          if (is_temp(chan))
          begin
            if (avg_cnt == `MCMC_TEMP_AVG_LAST)                         // RULE_13
            begin
              next_result.valid = 1'b1;
              next_result.chan  = chan;
              next_result.data  = sum[11:4];                            // RULE_14
              next_acc          = 12'sh000;
              next_avg_cnt      = 4'h0;
              next_chan         = chan_after(chan, mode);               // RULE_15
            end
            else
            begin
              next_acc     = sum;
              next_avg_cnt = avg_cnt + 4'h1;
            end
          end
          else
          begin
            next_result.valid = 1'b1;
            next_result.chan  = chan;
            next_result.data  = i_adc_raw[8] ? `MCMC_FULL_CODE : i_adc_raw[7:0]; // RULE_11
            next_chan         = chan_after(chan, mode);                 // RULE_15
          end
        end
      end
      default:
      begin
        next_state = mcmc_pkg::MCMC_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state   <= mcmc_pkg::MCMC_ST_WAIT;
      chan    <= mcmc_pkg::MCMC_CH_12V;
      timer   <= 18'h0_0000;
      avg_cnt <= 4'h0;
      acc     <= 12'sh000;
      start   <= 1'b0;
      result  <= '0;
    end
    else
    begin
      state   <= next_state;
      chan    <= next_chan;
      timer   <= next_timer;
      avg_cnt <= next_avg_cnt;
      acc     <= next_acc;
      start   <= next_start;
      result  <= next_result;
    end
  end

  assign o_adc_start = start;   // RULE_09
  assign o_mux_sel   = chan;    // RULE_09
  assign o_result    = result;

  // ****************************************
  // Checks
  // ****************************************
  // Cycles since last start, saturating
  logic [17:0] gap;
  logic [17:0] next_gap;

  always_comb
  begin
    next_gap = start ? 18'h0_0001 : ((gap == 18'h3_FFFF) ? gap : gap + 18'h0_0001);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gap <= 18'h0_0000;
    end
    else
    begin
      gap <= next_gap;
    end
  end

  a_aux_sel: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_01
    (o_cfg.aux_a_sel == o_reg_rdata[0]) && (o_cfg.aux_b_sel == o_reg_rdata[1]))
    else $error("aux select differs from mode bits");

  a_diode_b_sel: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_02
    i_reg_wr |=> (o_cfg.diode_b_sel == $past(i_reg_wdata[2])))
    else $error("diode b select not taken from write");

  a_vcc_range: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_03
    o_cfg.vcc_5v == o_reg_rdata[3])
    else $error("supply range differs from mode bit 3");

  a_irq_gate: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_04
    !o_reg_rdata[7] |-> (o_cfg.irq_en == 5'h00) && !o_cfg.vid_irq_mode)
    else $error("interrupt enable outside interrupt mode");

  a_irq_low_en: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_05
    o_reg_rdata[7] |-> o_cfg.irq_en[2:0] == o_reg_rdata[6:4])
    else $error("low interrupt enables differ from mode bits");

  a_irq_high_en: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_06
    o_reg_rdata[7] |-> o_cfg.irq_en[4:3] == $past(i_cfg2_irq_en))
    else $error("high interrupt enables differ from second config");

  a_conv_period: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_12
    o_adc_start && !is_temp(o_mux_sel) |-> gap >= CONV_GAP)
    else $error("voltage conversion started too early");

  a_temp_period: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_13
    o_adc_start && is_temp(o_mux_sel) |-> gap >= TEMP_GAP)
    else $error("diode conversion started too early");

  a_saturate: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_11
    $past(state == mcmc_pkg::MCMC_ST_CONV && i_adc_done && i_adc_raw[8] && !is_temp(chan))
    |-> o_result.valid && (o_result.data == `MCMC_FULL_CODE))
    else $error("overrange result not saturated");

  a_volt_code: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_09
    $past(state == mcmc_pkg::MCMC_ST_CONV && i_adc_done && !i_adc_raw[8] && !is_temp(chan))
    |-> o_result.valid && (o_result.data == $past(i_adc_raw[7:0])))
    else $error("in-range voltage code not passed through");

  a_temp_avg: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_13
    o_result.valid && is_temp(o_result.chan) |-> $past(avg_cnt) == `MCMC_TEMP_AVG_LAST)
    else $error("diode result before sixteen conversions");

  a_skip_off: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_15
    o_result.valid && !$past(i_reg_wr) |-> chan_on(o_mux_sel, o_reg_rdata))
    else $error("sequencer moved to a disabled channel");

endmodule : mcmc_ctrl

// *** verif/mcmc_ctrl_tb.sv ***
`timescale 1ns/1ps
module mcmc_ctrl_tb;

  // ****************************************
  // Bench signals
  // ****************************************
  localparam int CONV = 20;
  localparam int TEMP = 16;

  logic                   i_clk;
  logic                   i_resetn;
  logic                   i_reg_wr;
  logic [7:0]             i_reg_wdata;
  logic [7:0]             o_reg_rdata;
  logic [1:0]             i_cfg2_irq_en;
  mcmc_pkg::mcmc_cfg_t    o_cfg;
  logic                   i_run;
  logic                   o_adc_start;
  mcmc_pkg::mcmc_chan_t   o_mux_sel;
  logic                   i_adc_done;
  logic [8:0]             i_adc_raw;
  mcmc_pkg::mcmc_result_t o_result;
  int                     num_errors;
  int                     cmp_count;
  int                     cyc = 0;
  int                     last_st;

  mcmc_ctrl #(.CONV_CYCLES(CONV), .TEMP_CYCLES(TEMP)) uut (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_reg_wr      (i_reg_wr),
    .i_reg_wdata   (i_reg_wdata),
    .o_reg_rdata   (o_reg_rdata),
    .i_cfg2_irq_en (i_cfg2_irq_en),
    .o_cfg         (o_cfg),
    .i_run         (i_run),
    .o_adc_start   (o_adc_start),
    .o_mux_sel     (o_mux_sel),
    .i_adc_done    (i_adc_done),
    .i_adc_raw     (i_adc_raw),
    .o_result      (o_result)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) cyc <= cyc + 1;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic mcmc_pkg::mcmc_cfg_t exp_cfg(input logic [7:0] m, input logic [1:0] c);
    exp_cfg.aux_a_sel    = m[0];
    exp_cfg.aux_b_sel    = m[1];
    exp_cfg.diode_b_sel  = m[2];
    exp_cfg.vcc_5v       = m[3];
    exp_cfg.vid_irq_mode = m[7];
    exp_cfg.irq_en       = {c, m[6:4]} & {5{m[7]}};
  endfunction : exp_cfg

  // Keep holds the strobe up for a back-to-back write
  task automatic wr(input logic [7:0] v, input logic keep = 1'b0);
    i_reg_wr    = 1'b1;
    i_reg_wdata = v;
    @(negedge i_clk);
    if (!keep)
    begin
      i_reg_wr    = 1'b0;
      i_reg_wdata = ~v;
    end
  endtask : wr

  // One conversion: wait start, answer, judge result
  task automatic conv(input logic [3:0] ch, input int per, input logic [8:0] raw,
                      input logic res, input logic [7:0] e);
    int n;
    n = 0;
    while (o_adc_start !== 1'b1)
    begin
      if (n == 300)
      begin
        num_errors++;
        report_and_stop();
      end
      @(negedge i_clk);
      n++;
    end
    chk("mux_sel", 16'(o_mux_sel), 16'(ch));
    if (per != 0)
      chk("spacing", 16'(cyc - last_st), 16'(per));
    last_st = cyc;
    @(negedge i_clk);
    @(negedge i_clk);
    i_adc_done = 1'b1;
    i_adc_raw  = raw;
    @(negedge i_clk);
    i_adc_done = 1'b0;
    i_adc_raw  = ~raw;
    chk("valid", 16'(o_result.valid), 16'(res));
    if (res)
    begin
      chk("chan", 16'(o_result.chan), 16'(ch));
      chk("data", 16'(o_result.data), 16'(e));
    end
  endtask : conv

  task automatic diode(input logic [3:0] ch, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] e, input int per0);
    for (int k = 0; k < 16; k++)
      conv(ch, (k == 0) ? per0 : TEMP, {1'b1, k[0] ? b : a}, k == 15, e);
  endtask : diode

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    chk("rdata", 16'(o_reg_rdata), 16'h0000);
    chk("cfg", 16'(o_cfg), 16'h0000);
    chk("mux_sel", 16'(o_mux_sel), 16'h0000);
    chk("result", 16'(o_result), 16'h0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_cfg;
    logic [7:0] m [8];
    m = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h70, 8'hF0, 8'h90, 8'hFF};
    for (int i = 0; i < 8; i++)
    begin
      i_cfg2_irq_en = i[1:0];
      wr(m[i]);
      @(negedge i_clk);
      chk("rdata", 16'(o_reg_rdata), 16'(m[i]));
      chk("cfg", 16'(o_cfg), 16'(exp_cfg(m[i], i[1:0])));
    end
    wr(8'h55, 1'b1);
    chk("rdata b2b", 16'(o_reg_rdata), 16'h0055);
    wr(8'hAA);
    chk("rdata b2b", 16'(o_reg_rdata), 16'h00AA);
    chk("cfg b2b", 16'(o_cfg), 16'(exp_cfg(8'hAA, 2'b11)));
    $display("test cfg done");
  endtask : test_cfg

  task automatic test_seq_default;
    @(negedge i_clk);
    wr(8'h00);
    i_run = 1'b1;
    conv(4'h0, 0, 9'h0C0, 1'b1, 8'hC0);
    conv(4'h1, CONV, 9'h123, 1'b1, 8'hFF);
    conv(4'h2, CONV, 9'h000, 1'b1, 8'h00);
    conv(4'h3, CONV, 9'h0FE, 1'b1, 8'hFE);
    diode(4'h4, 8'hFD, 8'hFC, 8'hFC, TEMP);
    conv(4'h7, CONV, 9'h05A, 1'b1, 8'h5A);
    conv(4'h8, CONV, 9'h0A5, 1'b1, 8'hA5);
    conv(4'h0, CONV, 9'h001, 1'b1, 8'h01);
    i_run = 1'b0;
    $display("test seq default done");
  endtask : test_seq_default

  task automatic test_seq_all;
    @(negedge i_clk);
    wr(8'h07);
    i_run = 1'b1;
    conv(4'h1, 0, 9'h011, 1'b1, 8'h11);
    conv(4'h2, CONV, 9'h022, 1'b1, 8'h22);
    conv(4'h3, CONV, 9'h033, 1'b1, 8'h33);
    diode(4'h4, 8'h19, 8'h19, 8'h19, TEMP);
    conv(4'h5, CONV, 9'h055, 1'b1, 8'h55);
    conv(4'h6, CONV, 9'h066, 1'b1, 8'h66);
    diode(4'h9, 8'h80, 8'h82, 8'h81, TEMP);
    conv(4'h0, CONV, 9'h1FF, 1'b1, 8'hFF);
    i_run = 1'b0;
    $display("test seq all done");
  endtask : test_seq_all

  // Reset while running clears mode, pin functions and sequencer
  task automatic test_reset_mid;
    wr(8'hFF);
    i_run = 1'b1;
    repeat (5) @(negedge i_clk);
    i_resetn = 1'b0;
    @(negedge i_clk);
    test_reset();
    i_run    = 1'b0;
    i_resetn = 1'b1;
    @(negedge i_clk);
    test_reset();
    $display("test reset mid done");
  endtask : test_reset_mid

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    num_errors    = 0;
    cmp_count     = 0;
    last_st       = 0;
    i_resetn      = 1'b0;
    i_reg_wr      = 1'b0;
    i_reg_wdata   = 8'h00;
    i_cfg2_irq_en = 2'b00;
    i_run         = 1'b0;
    i_adc_done    = 1'b0;
    i_adc_raw     = 9'h000;
    repeat (10) @(negedge i_clk);
    test_reset();
    i_resetn = 1'b1;
    @(negedge i_clk);
    test_reset();
    test_cfg();
    test_seq_default();
    test_seq_all();
    test_reset_mid();
    report_and_stop();
  end

endmodule : mcmc_ctrl_tb
